// ===== design/reset_source_control.sv
// Reset source controller: merges six reset sources, keeps cause flags.
// Assumes all inputs synchronous to sys_clk_i except the shared pin.
// Functional notes
// - Pin is reset when select bit set
// - Power-up always uses pin as reset
// - Only power-up overrides pin selection
// - Six reset sources enter reset
// - One sticky cause flag per source
// - Writing zero clears a cause flag
// - Power-on sets power and brownout flags only
// - Other resets keep uncleared flags
// - Config byte loaded at power-up only
// - Brownout resets, or interrupts if configured
// - Power-on flag stays until cleared
`default_nettype none
module reset_source_control
	import reset_source_pkg::*;
#(
	parameter int unsigned HOLD_CYC = RST_HOLD_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic shared_input_pin_i,
	input wire logic power_on_det_i,
	input wire logic brownout_det_i,
	input wire logic watchdog_i,
	input wire logic uart_break_i,
	input wire logic [DATA_W-1:0] user_config_byte_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic sys_reset_o,
	output logic pin_data_o,
	output logic irq_o
);
	typedef enum logic [1:0] {ST_POWERUP, ST_LOAD, ST_RUN, ST_HOLD} state_type;

	state_type state_q, state_d;
	logic pin_s1_q, pin_s2_q;
	logic [DATA_W-1:0] cfg_q, cfg_d;
	logic [NUM_CAUSE-1:0] cause_q, cause_d;
	logic [1:0] ctrl_q, ctrl_d;
	logic [1:0] ists_q, ists_d;
	logic [1:0] imask_q, imask_d;
	logic [7:0] hold_q, hold_d;
	logic [DATA_W-1:0] rdata_d;
	logic rst_out_d, pin_out_d, irq_d;
	logic pin_rst_en, pin_low, bo_reset, any_src;
	logic [NUM_CAUSE-1:0] src;
	logic bo_q;

	// Pin synchroniser; first stage only feeds the second
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			bo_q <= 1'b0;
		end else begin
			pin_s1_q <= shared_input_pin_i;
			pin_s2_q <= pin_s1_q;
			bo_q <= brownout_det_i;
		end
	end

	always_comb begin
		// Power-up overrides the select; other resets do not
		pin_rst_en = (state_q == ST_POWERUP) || cfg_q[CFG_RPIN];
		pin_low = pin_rst_en && !pin_s2_q;
		bo_reset = brownout_det_i && !ctrl_q[CTRL_BOIRQ];
		src = '0;
		src[CAUSE_EXT] = pin_low && (state_q != ST_POWERUP);
		src[CAUSE_POR] = power_on_det_i;
		src[CAUSE_BO] = bo_reset;
		src[CAUSE_WDT] = watchdog_i;
		src[CAUSE_SW] = ctrl_q[CTRL_SWRST];
		src[CAUSE_BRK] = uart_break_i;
		any_src = |src;
	end

	// Sequencer: power-up waits for the pin, loads config, then runs
	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		unique case (state_q)
			ST_POWERUP: begin
				// A pin held low here keeps us in reset forever
				if (pin_s2_q && !power_on_det_i) begin
					state_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				state_d = ST_HOLD;
				hold_d = 8'(HOLD_CYC);
			end
			ST_RUN: begin
				if (power_on_det_i) begin
					state_d = ST_POWERUP;
				end else if (any_src) begin
					state_d = ST_HOLD;
					hold_d = 8'(HOLD_CYC);
				end
			end
			ST_HOLD: begin
				if (power_on_det_i) begin
					state_d = ST_POWERUP;
				end else if (any_src) begin
					hold_d = 8'(HOLD_CYC);
				end else if (hold_q <= 8'h01) begin
					state_d = ST_RUN;
					hold_d = 8'h00;
				end else begin
					hold_d = hold_q - 8'h01;
				end
			end
		endcase
	end

	// Registers and flags
	always_comb begin
		cfg_d = cfg_q;
		cause_d = cause_q;
		ctrl_d = ctrl_q;
		ists_d = ists_q;
		imask_d = imask_q;
		if (state_q == ST_LOAD) begin
			cfg_d = user_config_byte_i;
		end
		if (wr_i && state_q == ST_RUN) begin
			unique case (addr_i)
				CAUSE_OFS: cause_d = cause_q & wdata_i[NUM_CAUSE-1:0];
				CTRL_OFS: ctrl_d = wdata_i[1:0];
				IRQ_STAT_OFS: ists_d = ists_q & ~wdata_i[1:0];
				IRQ_MASK_OFS: imask_d = wdata_i[1:0];
				default: ;
			endcase
		end
		// Flag sets beat software clears
		if (power_on_det_i) begin
			cause_d = CAUSE_POR_VAL;
			ctrl_d = '0;
		end else if (any_src) begin
			cause_d = cause_d | src;
			ctrl_d[CTRL_SWRST] = 1'b0;
		end
		if (brownout_det_i && !bo_q && ctrl_q[CTRL_BOIRQ]) begin
			ists_d[IRQ_BO] = 1'b1;
		end
		if (watchdog_i) begin
			ists_d[IRQ_W] = 1'b1;
		end
	end

	always_comb begin
		rdata_d = '0;
		if (rd_i) begin
			unique case (addr_i)
				CAUSE_OFS: rdata_d = {2'h0, cause_q};
				CTRL_OFS: rdata_d = {6'h00, ctrl_q};
				IRQ_STAT_OFS: rdata_d = {6'h00, ists_q};
				IRQ_MASK_OFS: rdata_d = {6'h00, imask_q};
				CFG_OFS: rdata_d = cfg_q;
				default: rdata_d = '0;
			endcase
		end
		rst_out_d = (state_d != ST_RUN);
		// Pin reads high while it serves as reset
		pin_out_d = pin_rst_en ? 1'b1 : pin_s2_q;
		irq_d = |(ists_d & imask_d);
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= ST_POWERUP;
			hold_q <= 8'h00;
			cfg_q <= CFG_RST;
			cause_q <= CAUSE_POR_VAL;
			ctrl_q <= '0;
			ists_q <= '0;
			imask_q <= '0;
			rdata_o <= '0;
			sys_reset_o <= 1'b1;
			pin_data_o <= 1'b1;
			irq_o <= 1'b0;
		end else begin
			state_q <= state_d;
			hold_q <= hold_d;
			cfg_q <= cfg_d;
			cause_q <= cause_d;
			ctrl_q <= ctrl_d;
			ists_q <= ists_d;
			imask_q <= imask_d;
			rdata_o <= rdata_d;
			sys_reset_o <= rst_out_d;
			pin_data_o <= pin_out_d;
			irq_o <= irq_d;
		end
	end

	property p_por_flags;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		power_on_det_i |=> cause_q == CAUSE_POR_VAL;
	endproperty
	a_por_flags: assert property (p_por_flags) else $error("por flags");

	property p_keep_flags;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		!power_on_det_i && !wr_i |=> (cause_q & $past(cause_q)) == $past(cause_q);
	endproperty
	a_keep_flags: assert property (p_keep_flags) else $error("flag lost");

	property p_wdt_flag;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		watchdog_i && !power_on_det_i |=> cause_q[CAUSE_WDT];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("wdt flag");

	property p_clear;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		wr_i && addr_i == CAUSE_OFS && state_q == ST_RUN && !wdata_i[CAUSE_SW]
		&& !any_src && !power_on_det_i |=> !cause_q[CAUSE_SW];
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");

	property p_src_reset;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		any_src |=> sys_reset_o;
	endproperty
	a_src_reset: assert property (p_src_reset) else $error("no reset");

	property p_pin_hold;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		pin_low |=> sys_reset_o ##1 (sys_reset_o || HOLD_CYC < 2);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin hold");

	property p_pin_ignored;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		state_q != ST_POWERUP && !cfg_q[CFG_RPIN] |-> !src[CAUSE_EXT];
	endproperty
	a_pin_ignored: assert property (p_pin_ignored) else $error("pin sel");

	property p_cfg_stable;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		state_q == ST_RUN |=> cfg_q == $past(cfg_q);
	endproperty
	a_cfg_stable: assert property (p_cfg_stable) else $error("cfg moved");

	property p_bo_irq;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		brownout_det_i && ctrl_q[CTRL_BOIRQ] && !power_on_det_i
		|-> !src[CAUSE_BO];
	endproperty
	a_bo_irq: assert property (p_bo_irq) else $error("bo mode");

	// Software reset must fire once, not loop forever
	property p_sw_clr;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ctrl_q[CTRL_SWRST] |=> !ctrl_q[CTRL_SWRST];
	endproperty
	a_sw_clr: assert property (p_sw_clr) else $error("sw stuck");

	property p_pu_reset;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		state_q == ST_POWERUP |=> sys_reset_o;
	endproperty
	a_pu_reset: assert property (p_pu_reset) else $error("pu reset");

	property p_pu_pin;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		state_q == ST_POWERUP && !pin_s2_q |=> state_q == ST_POWERUP;
	endproperty
	a_pu_pin: assert property (p_pu_pin) else $error("pu pin");

	property p_bo_set;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		brownout_det_i && !bo_q && ctrl_q[CTRL_BOIRQ] |=> ists_q[IRQ_BO];
	endproperty
	a_bo_set: assert property (p_bo_set) else $error("bo irq lost");

	property p_wdt_irq;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		watchdog_i |=> ists_q[IRQ_W];
	endproperty
	a_wdt_irq: assert property (p_wdt_irq) else $error("wdt irq");

	property p_cause_rd;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		rd_i && addr_i == CAUSE_OFS |=> rdata_o == {2'h0, $past(cause_q)};
	endproperty
	a_cause_rd: assert property (p_cause_rd) else $error("cause rd");

	// Read data stand for one cycle only
	property p_rd_idle;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata stale");

	property p_ext_flag;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		src[CAUSE_EXT] && !power_on_det_i |=> cause_q[CAUSE_EXT];
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("ext flag");

	c_run: cover property (@(posedge sys_clk_i) state_q == ST_RUN);
	c_wdt: cover property (@(posedge sys_clk_i) state_q == ST_RUN ##1 watchdog_i);
	c_irq: cover property (@(posedge sys_clk_i) irq_o);
	c_pin: cover property (@(posedge sys_clk_i) src[CAUSE_EXT]);
endmodule
`default_nettype wire

// ===== design/reset_source_pkg.sv
// Constants for the reset source controller.
// Assumes a single 10 MHz core clock domain.
`default_nettype none
package reset_source_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	// Register offsets
	localparam logic [3:0] CAUSE_OFS = 4'h0;
	localparam logic [3:0] CTRL_OFS = 4'h1;
	localparam logic [3:0] IRQ_STAT_OFS = 4'h2;
	localparam logic [3:0] IRQ_MASK_OFS = 4'h3;
	localparam logic [3:0] CFG_OFS = 4'h4;
	// Cause register bit positions
	localparam int unsigned CAUSE_EXT = 0;
	localparam int unsigned CAUSE_POR = 1;
	localparam int unsigned CAUSE_BO = 2;
	localparam int unsigned CAUSE_WDT = 3;
	localparam int unsigned CAUSE_SW = 4;
	localparam int unsigned CAUSE_BRK = 5;
	localparam int unsigned NUM_CAUSE = 6;
	// Control register: bit0 software reset, bit1 brownout as interrupt
	localparam int unsigned CTRL_SWRST = 0;
	localparam int unsigned CTRL_BOIRQ = 1;
	// Config byte: bit0 reset pin select
	localparam int unsigned CFG_RPIN = 0;
	// Interrupt status bits
	localparam int unsigned IRQ_BO = 0;
	localparam int unsigned IRQ_W = 1;
	localparam logic [5:0] CAUSE_POR_VAL = 6'h06;
	localparam logic [DATA_W-1:0] CFG_RST = 8'h00;
	// Internal reset stretch after any source has gone
	localparam int unsigned RST_HOLD_NS = 400;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// ===== verif/ext_reset_circuit.sv
// External reset circuit on the shared pin; pulled up when released.
// Assumes power_on_i mirrors the power-on detect given to the block.
`default_nettype none
module ext_reset_circuit (
	input wire logic req_i,
	input wire logic violate_i,
	input wire logic power_on_i,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Never low during power-on unless a scenario breaks that on purpose
	assign pin_o = ~(req_i & (~power_on_i | violate_i));
endmodule
`default_nettype wire

// ===== verif/reset_source_control_tb.sv
// Self-checking bench for reset_source_control with a cause flag model.
// Assumes the external reset circuit model and the design package.
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	failures++; $display("Error %s exp %0h got %0h", n, e, g); end end
module reset_source_control_tb
	import reset_source_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 0, rst_b_i = 0, por = 1, bo = 0, wd = 0, brk = 0;
	logic req = 0, vio = 0, wr = 0, rd = 0, pin, sys_reset, pin_data, irq;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, cfg = 8'h01, rdata, x, c;
	int failures = 0, num_checks = 0, cause, seen, r;
	int bits[4] = '{CAUSE_WDT, CAUSE_BRK, CAUSE_BO, CAUSE_EXT};
	always #50 sys_clk_i = ~sys_clk_i;
	ext_reset_circuit ext_reset_circuit_inst (.req_i(req), .violate_i(vio),
		.power_on_i(por), .pin_o(pin));
	reset_source_control reset_source_control_inst (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .shared_input_pin_i(pin),
		.power_on_det_i(por), .brownout_det_i(bo), .watchdog_i(wd),
		.uart_break_i(brk), .user_config_byte_i(cfg), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.sys_reset_o(sys_reset), .pin_data_o(pin_data), .irq_o(irq));
	task automatic final_report;
		if (failures == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge sys_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		@(negedge sys_clk_i);
		x = rdata;
	endtask
	// Bounded wait that notes whether the internal reset was seen at all
	task automatic wait_run;
		seen = 0;
		for (int i = 0; i < 40; i++) begin
			@(negedge sys_clk_i);
			if (sys_reset === 1'b1) seen = 1;
			else if (seen == 1) break;
		end
	endtask
	task automatic pulse(input int k);
		@(posedge sys_clk_i);
		case (k)
			0: wd <= 1'b1;
			1: brk <= 1'b1;
			2: bo <= 1'b1;
			default: req <= 1'b1;
		endcase
		repeat (k + 1) @(posedge sys_clk_i);
		{wd, brk, bo, req} <= 4'h0;
		wait_run;
	endtask
	task automatic boot(input logic [7:0] v, input logic hold);
		@(posedge sys_clk_i);
		rst_b_i <= 1'b0;
		por <= 1'b1;
		cfg <= v;
		req <= hold;
		vio <= hold;
		repeat (5) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		por <= 1'b0;
		repeat (10) @(negedge sys_clk_i);
		if (hold) `CHK("held", 1'b1, sys_reset)
		@(posedge sys_clk_i);
		{req, vio} <= 2'h0;
		wait_run;
		cause = 6;
	endtask
	initial begin
		#(5000 * 100);
		failures++;
		final_report;
	end
	initial begin
		void'($urandom(4965));
		c = 8'($urandom) | 8'h01;
		boot(c, 1'b0);
		rd_reg(CAUSE_OFS);
		`CHK("cause", cause, x)
		`CHK("pin data", 1'b1, pin_data)
		@(posedge sys_clk_i);
		cfg <= ~c;
		wr_reg(CFG_OFS, 8'h00);
		rd_reg(CFG_OFS);
		`CHK("cfg", c, x)
		rd_reg(4'hF);
		`CHK("unmapped", 0, x)
		r = $urandom;
		wr_reg(CAUSE_OFS, 8'(r));
		cause &= r;
		rd_reg(CAUSE_OFS);
		`CHK("cause", cause, x)
		wr_reg(CAUSE_OFS, 8'h00);
		cause = 0;
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			`CHK("reset", 1, seen)
			cause |= 1 << bits[k];
			rd_reg(CAUSE_OFS);
			`CHK("cause", cause, x)
		end
		wr_reg(CTRL_OFS, 8'h01);
		wait_run;
		`CHK("sw reset", 1, seen)
		cause |= 1 << CAUSE_SW;
		rd_reg(CAUSE_OFS);
		`CHK("cause", cause, x)
		wr_reg(IRQ_STAT_OFS, 8'hFF);
		wr_reg(IRQ_MASK_OFS, 8'h00);
		wr_reg(CTRL_OFS, 8'h02);
		pulse(2);
		`CHK("bo reset", 0, seen)
		rd_reg(IRQ_STAT_OFS);
		`CHK("irq stat", 8'h01, x)
		`CHK("irq masked", 1'b0, irq)
		wr_reg(IRQ_MASK_OFS, 8'h01);
		repeat (2) @(negedge sys_clk_i);
		`CHK("irq", 1'b1, irq)
		wr_reg(IRQ_STAT_OFS, 8'h01);
		repeat (2) @(negedge sys_clk_i);
		`CHK("irq clr", 1'b0, irq)
		boot(8'h00, 1'b1);
		pulse(0);
		cause |= 1 << CAUSE_WDT;
		@(posedge sys_clk_i);
		req <= 1'b1;
		wait_run;
		`CHK("pin ignored", 0, seen)
		`CHK("pin data", 1'b0, pin_data)
		@(posedge sys_clk_i);
		req <= 1'b0;
		rd_reg(CAUSE_OFS);
		`CHK("cause", cause, x)
		final_report;
	end
endmodule
`default_nettype wire
